// file: common/mctu_params.svh
`ifndef MCTU_PARAMS_SVH
`define MCTU_PARAMS_SVH

// ***************************************************************
// Register word indices on the internal bus
// ***************************************************************
`define MCTU_ADDR_CTL0 4'h0
`define MCTU_ADDR_CNT0 4'h5
`define MCTU_ADDR_BUF0 4'hA

// ***************************************************************
// Reset values and fixed bits
// ***************************************************************
`define MCTU_CTL_RST 8'h80
`define MCTU_CTL_FIXED 8'h80
`define MCTU_CTL_FIXED_BIT 7
`define MCTU_BUF_RST 16'hFFFF
`define MCTU_CNT_RST 16'h0000
`define MCTU_CNT_STEP 16'h0001
`define MCTU_RD_IDLE 16'h0000
`define MCTU_BYTE_ZERO 8'h00
`define MCTU_DIV_RST 3'h0
`define MCTU_DIV_STEP 3'h1

// ***************************************************************
// Control register fields and codes
// ***************************************************************
`define MCTU_CLR_HI 6
`define MCTU_CLR_LO 5
`define MCTU_EDGE_HI 4
`define MCTU_EDGE_LO 3
`define MCTU_SRC_HI 2
`define MCTU_SRC_LO 0
`define MCTU_CLR_NONE 2'h0
`define MCTU_CLR_GEN_A 2'h1
`define MCTU_CLR_GEN_B 2'h2
`define MCTU_CLR_SYNC 2'h3
`define MCTU_EDGE_RISE 2'h0
`define MCTU_EDGE_FALL 2'h1
`define MCTU_SRC_DIV1 3'h0
`define MCTU_SRC_DIV2 3'h1
`define MCTU_SRC_DIV4 3'h2
`define MCTU_SRC_DIV8 3'h3
`define MCTU_PHASE_CH 2
`define MCTU_BUF_CH0 3

`endif

// file: common/mctu_pkg.sv
`default_nettype none

// ***************************************************************
// Shared types
// ***************************************************************
package mctu_pkg;
  typedef logic [15:0] mctu_word_type;
  typedef logic [7:0] mctu_byte_type;
endpackage : mctu_pkg

`default_nettype wire

// file: hw/mctu_timer_clk_buf.sv
// Summary of operation
// [RL1] Buffers A and B only in channels 3, 4
// [RL2] Compare match copies buffer into general register
// [RL3] Capture moves old general value into buffer
// [RL4] Each buffer has its own enable bit
// [RL5] Buffers readable, writable by word or byte
// [RL6] Buffers reset to all ones, also standby
// [RL7] Five 8-bit control registers, identical behaviour
// [RL8] Control resets to 0x80, bit 7 reads one
// [RL9] Clear field: none, A, B, synchronous
// [RL10] Clear on match or capture per mode
// [RL11] Synchronous clear follows other synchronized channels
// [RL12] Edge field: rise, fall, or both edges
// [RL13] Codes 0 to 3 divide clock by 1-8
// [RL14] Codes 4 to 7 select external inputs A-D
// [RL15] Internal clocks ignore edge field, external obey
// [RL16] Channel 2 phase mode overrides clock fields
// [RL17] Sixteen-bit counters cleared to zero
// [RL18] External inputs synchronized, edges detected registered
`timescale 1ns/1ps
`default_nettype none
`include "mctu_params.svh"

module mctu_timer_clk_buf (
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  input wire logic [3:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [1:0] bus_byte_en,
  input wire mctu_pkg::mctu_word_type bus_wdata,
  output var mctu_pkg::mctu_word_type bus_rdata,
  input wire logic ext_count_in_a,
  input wire logic ext_count_in_b,
  input wire logic ext_count_in_c,
  input wire logic ext_count_in_d,
  input wire logic phase_count_mode_bit,
  input wire logic phase_up,
  input wire logic phase_down,
  input wire logic [4:0] channel_sync_reg,
  input wire logic [3:0] buffer_enable,
  input wire logic [4:0] general_reg_a_capture,
  input wire logic [4:0] general_reg_b_capture,
  input wire logic [4:0] match_a,
  input wire logic [4:0] match_b,
  input wire logic [4:0] capture_a,
  input wire logic [4:0] capture_b,
  input wire logic [3:0][15:0] general_reg_value,
  output logic [3:0] buffer_load,
  output logic [3:0][15:0] buffer_value,
  output logic [4:0][15:0] channel_counter
);
  import mctu_pkg::*;

  mctu_byte_type ctl_reg [5];
  mctu_word_type cnt_reg [5];
  mctu_word_type buf_reg [4];
  mctu_word_type rd_next;
  logic [2:0] div_reg;
  logic [2:0] pre_tick;
  logic [3:0] ext_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] ext_rise;
  logic [3:0] ext_fall;
  logic [4:0] own_clr;
  logic [4:0] clr_now;
  logic sync_evt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ***************************************************************
  // Prescaler and external input sampling
  // ***************************************************************

  // Free running divider, ticks mark prescaled falling edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      div_reg <= `MCTU_DIV_RST;
    else if (standby)
      div_reg <= `MCTU_DIV_RST;
    else
      div_reg <= div_reg + `MCTU_DIV_STEP;
  end

  // One-cycle ticks for divide by 2, 4 and 8
  assign pre_tick = {&div_reg, &div_reg[1:0], div_reg[0]}; // RL13

  assign ext_in = {ext_count_in_d, ext_count_in_c,
                   ext_count_in_b, ext_count_in_a};

  // Two-stage synchronizer plus one stage for edge history
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end
    else
    begin
      sync1_reg <= ext_in; // RL18
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Edges taken from synchronized stages only
  assign ext_rise = sync2_reg & ~sync3_reg; // RL18
  assign ext_fall = ~sync2_reg & sync3_reg; // RL18

  // Channels marked for synchronous clear share any member's event
  assign sync_evt = |(own_clr & channel_sync_reg); // RL11

  // ***************************************************************
  // Per-channel control register, clock select and counter
  // ***************************************************************
  for (genvar i = 0; i < 5; i++)
  begin : ch_g
    logic [2:0] src;
    logic [1:0] edg;
    logic [1:0] clm;
    logic ext_ev;
    logic tick;
    logic phase;
    logic ev_a;
    logic ev_b;
    logic ctl_hit;

    assign src = ctl_reg[i][`MCTU_SRC_HI:`MCTU_SRC_LO];
    assign edg = ctl_reg[i][`MCTU_EDGE_HI:`MCTU_EDGE_LO];
    assign clm = ctl_reg[i][`MCTU_CLR_HI:`MCTU_CLR_LO];
    assign phase = (i == `MCTU_PHASE_CH) && phase_count_mode_bit;
    assign ctl_hit = bus_wr && bus_byte_en[0] &&
                     (bus_addr == `MCTU_ADDR_CTL0 + 4'(i));

    // Control register, bit 7 held at one
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        ctl_reg[i] <= `MCTU_CTL_RST; // RL8
      else if (standby)
        ctl_reg[i] <= `MCTU_CTL_RST; // RL8
      else if (ctl_hit)
        ctl_reg[i] <= `MCTU_CTL_FIXED | bus_wdata[7:0]; // RL7
    end

    // Event on the chosen external edge or edges
    always_comb
    begin
      case (edg)
        `MCTU_EDGE_RISE: ext_ev = ext_rise[src[1:0]]; // RL12
        `MCTU_EDGE_FALL: ext_ev = ext_fall[src[1:0]]; // RL12
        default: ext_ev = ext_rise[src[1:0]] | ext_fall[src[1:0]];
      endcase
    end

    // Clock source: internal prescaler or external input
    always_comb
    begin
      case (src)
        `MCTU_SRC_DIV1: tick = 1'b1; // RL15
        `MCTU_SRC_DIV2: tick = pre_tick[0]; // RL13
        `MCTU_SRC_DIV4: tick = pre_tick[1]; // RL13
        `MCTU_SRC_DIV8: tick = pre_tick[2]; // RL13
        default: tick = ext_ev; // RL14
      endcase
    end

    // General register events: capture or match by its mode
    assign ev_a = general_reg_a_capture[i] ? capture_a[i] : match_a[i];
    assign ev_b = general_reg_b_capture[i] ? capture_b[i] : match_b[i];

    // Clear source decode
    assign own_clr[i] = (clm == `MCTU_CLR_GEN_A && ev_a) || // RL10
                        (clm == `MCTU_CLR_GEN_B && ev_b); // RL9
    assign clr_now[i] = own_clr[i] || (clm == `MCTU_CLR_SYNC &&
                        channel_sync_reg[i] && sync_evt); // RL11

    // Counter: clear beats counting, phase mode beats clock select
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        cnt_reg[i] <= `MCTU_CNT_RST;
      else if (standby)
        cnt_reg[i] <= `MCTU_CNT_RST;
      else if (clr_now[i])
        cnt_reg[i] <= `MCTU_CNT_RST; // RL17
      else if (phase)
      begin
        if (phase_up && !phase_down)
          cnt_reg[i] <= cnt_reg[i] + `MCTU_CNT_STEP; // RL16
        else if (phase_down && !phase_up)
          cnt_reg[i] <= cnt_reg[i] - `MCTU_CNT_STEP; // RL16
      end
      else if (tick)
        cnt_reg[i] <= cnt_reg[i] + `MCTU_CNT_STEP; // RL15
    end

    assign channel_counter[i] = cnt_reg[i];

    // Checks for control register and counter behaviour
    a_ctl_bit_high: assert property ( // RL8
      ctl_reg[i][`MCTU_CTL_FIXED_BIT])
      else $error("control bit 7 not one");
    a_clear_to_zero: assert property ( // RL10
      clr_now[i] && !standby |=> cnt_reg[i] == `MCTU_CNT_RST)
      else $error("counter not cleared");
    a_sync_clear_ch: assert property ( // RL11
      clm == `MCTU_CLR_SYNC && channel_sync_reg[i] && sync_evt
      |=> cnt_reg[i] == `MCTU_CNT_RST)
      else $error("sync clear missed");
    a_div1_count: assert property ( // RL13
      src == `MCTU_SRC_DIV1 && !clr_now[i] && !standby && !phase
      |=> cnt_reg[i] == $past(cnt_reg[i]) + `MCTU_CNT_STEP)
      else $error("div1 count wrong");
    a_no_tick_hold: assert property ( // RL15
      !tick && !clr_now[i] && !standby && !phase
      |=> $stable(cnt_reg[i]))
      else $error("counted without tick");
    a_div8_spacing: assert property ( // RL13
      src == `MCTU_SRC_DIV8 && tick && !phase
      |=> (!tick || src != `MCTU_SRC_DIV8) [*7])
      else $error("div8 tick too close");
    if (i == `MCTU_PHASE_CH)
    begin : ph_g
      a_phase_override: assert property ( // RL16
        phase && phase_up && !phase_down && !clr_now[i] && !standby
        |=> cnt_reg[i] == $past(cnt_reg[i]) + `MCTU_CNT_STEP)
        else $error("phase count ignored");
      c_phase_count: cover property (phase && phase_down);
    end
  end

  // ***************************************************************
  // Buffer registers of channels 3 and 4
  // ***************************************************************
  for (genvar k = 0; k < 4; k++)
  begin : buf_g
    localparam int CH = `MCTU_BUF_CH0 + k / 2; // RL1
    logic is_cap;
    logic cap_ev;
    logic cmp_ev;
    logic hit;

    // Even entries pair with A, odd entries with B
    assign is_cap = (k % 2 == 0) ? general_reg_a_capture[CH]
                                 : general_reg_b_capture[CH];
    assign cap_ev = (k % 2 == 0) ? capture_a[CH] : capture_b[CH];
    assign cmp_ev = (k % 2 == 0) ? match_a[CH] : match_b[CH];
    assign hit = bus_wr && (bus_addr == `MCTU_ADDR_BUF0 + 4'(k));

    // Compare match loads buffer into its general register
    assign buffer_load[k] = buffer_enable[k] && !is_cap && cmp_ev; // RL2

    // Capture shifts old general value in; beats a bus write
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        buf_reg[k] <= `MCTU_BUF_RST; // RL6
      else if (standby)
        buf_reg[k] <= `MCTU_BUF_RST; // RL6
      else if (buffer_enable[k] && is_cap && cap_ev) // RL4
        buf_reg[k] <= general_reg_value[k]; // RL3
      else if (hit)
      begin
        if (bus_byte_en[0])
          buf_reg[k][7:0] <= bus_wdata[7:0]; // RL5
        if (bus_byte_en[1])
          buf_reg[k][15:8] <= bus_wdata[15:8]; // RL5
      end
    end

    assign buffer_value[k] = buf_reg[k];

    // Checks for buffering
    a_buf_capture: assert property ( // RL3
      buffer_enable[k] && is_cap && cap_ev && !standby
      |=> buf_reg[k] == $past(general_reg_value[k]))
      else $error("capture buffer wrong");
    a_buf_load_cause: assert property ( // RL2
      buffer_load[k] |-> cmp_ev && !is_cap && buffer_value[k] == buf_reg[k])
      else $error("buffer load without match");
    a_buf_off_quiet: assert property ( // RL4
      !buffer_enable[k] && !hit && !standby |=> $stable(buf_reg[k]))
      else $error("disabled buffer changed");
    a_byte_write_lo: assert property ( // RL5
      hit && bus_byte_en == 2'h1 && !standby &&
      !(buffer_enable[k] && is_cap && cap_ev)
      |=> buf_reg[k][7:0] == $past(bus_wdata[7:0]) &&
          buf_reg[k][15:8] == $past(buf_reg[k][15:8]))
      else $error("byte write wrong");
    a_standby_init: assert property ( // RL6
      standby |=> buf_reg[k] == `MCTU_BUF_RST)
      else $error("buffer not reset by standby");
  end

  // ***************************************************************
  // Bus read path
  // ***************************************************************

  // Read decode, unmapped words read zero
  always_comb
  begin
    rd_next = `MCTU_RD_IDLE;
    for (int n = 0; n < 5; n++)
    begin
      if (bus_addr == `MCTU_ADDR_CTL0 + 4'(n))
        rd_next = {`MCTU_BYTE_ZERO, ctl_reg[n]}; // RL7
      if (bus_addr == `MCTU_ADDR_CNT0 + 4'(n))
        rd_next = cnt_reg[n];
    end
    for (int n = 0; n < 4; n++)
    begin
      if (bus_addr == `MCTU_ADDR_BUF0 + 4'(n))
        rd_next = buf_reg[n]; // RL5
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_rdata <= `MCTU_RD_IDLE;
    else if (bus_rd)
      bus_rdata <= rd_next;
  end

  // Scenario coverage
  c_buf_capture: cover property (
    buffer_enable[0] && general_reg_a_capture[3] && capture_a[3]);
  c_buf_load: cover property (buffer_load[3]);
  c_sync_clear: cover property (sync_evt && |clr_now);
  c_ext_both: cover property (ext_rise[1] ##[1:20] ext_fall[1]);

endmodule : mctu_timer_clk_buf

`default_nettype wire

// file: tb/mctu_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mctu_params.svh"

module tb;
  import mctu_pkg::*;
  typedef struct {string name; mctu_word_type exp; mctu_word_type mask;
    bit rel;} mctu_note_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic bus_rd = 1'b0, bus_wr = 1'b0;
  logic [1:0] bus_byte_en = 2'h0;
  mctu_word_type bus_wdata = 16'h0000, bus_rdata, prev_rd = 16'h0000;
  logic [3:0] ext = 4'h0, buffer_enable = 4'h0, buffer_load;
  logic phase_mode = 1'b0, phase_up = 1'b0, phase_down = 1'b0;
  logic [4:0] sync = 5'h00, gcap_a = 5'h00, gcap_b = 5'h00;
  logic [4:0] match_a = 5'h00, match_b = 5'h00;
  logic [4:0] capture_a = 5'h00, capture_b = 5'h00;
  logic [3:0][15:0] gval = '0, buffer_value;
  logic [4:0][15:0] channel_counter;
  logic rd_d = 1'b0;
  mctu_note_type notes [$];
  int n_errors = 0;
  int n_checks = 0;
  int seed = 51660;
  mctu_byte_type clr_ctl [9] = '{8'h24, 8'h24, 8'h24, 8'h24, 8'h44, 8'h44,
    8'h04, 8'h64, 8'h44};
  logic [4:0] clr_ev [9] = '{5'h08, 5'h02, 5'h02, 5'h08, 5'h04, 5'h08,
    5'h0f, 5'h10, 5'h01};
  logic [8:0] clr_mode = 9'h10c;
  logic [8:0] clr_zero = 9'h195;
  mctu_word_type ph_exp [4] = '{16'h0000, 16'h0010, 16'hfff0, 16'h0000};

  mctu_timer_clk_buf mctu_timer_clk_buf_inst (
    .clk(clk), .rst(rst), .standby(standby), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_byte_en(bus_byte_en),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .ext_count_in_a(ext[0]), .ext_count_in_b(ext[1]),
    .ext_count_in_c(ext[2]), .ext_count_in_d(ext[3]),
    .phase_count_mode_bit(phase_mode), .phase_up(phase_up),
    .phase_down(phase_down), .channel_sync_reg(sync),
    .buffer_enable(buffer_enable), .general_reg_a_capture(gcap_a),
    .general_reg_b_capture(gcap_b), .match_a(match_a), .match_b(match_b),
    .capture_a(capture_a), .capture_b(capture_b),
    .general_reg_value(gval), .buffer_load(buffer_load),
    .buffer_value(buffer_value), .channel_counter(channel_counter));

  // ***************************************************************
  // Clock, shared tasks and result monitor
  // ***************************************************************
  always #2 clk = ~clk;

  task automatic chk(input string name, input mctu_word_type exp,
    input mctu_word_type got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Bus cycle, then one idle cycle so strobes never toggle twice
  task automatic wr(input logic [3:0] a, input logic [1:0] be,
    input mctu_word_type d);
    bus_addr = a;
    bus_byte_en = be;
    bus_wdata = d;
    bus_wr = 1'b1;
    cyc(1);
    bus_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [3:0] a, input string name,
    input mctu_word_type exp, input mctu_word_type mask, input bit rel);
    notes.push_back('{name, exp, mask, rel});
    bus_addr = a;
    bus_rd = 1'b1;
    cyc(1);
    bus_rd = 1'b0;
    cyc(1);
  endtask : rd

  // Bump ch1 by one edge, raise an event, then check clear or hold
  task automatic clr_case(input mctu_byte_type ctl, input logic [4:0] ev,
    input logic mode, input logic zero);
    wr(4'h1, 2'b01, {8'h00, ctl});
    gcap_a[1] = mode;
    gcap_b[1] = mode;
    ext[0] = 1'b1;
    cyc(6);
    ext[0] = 1'b0;
    cyc(6);
    rd(4'h6, "base", 16'h0000, 16'h0000, 1'b0);
    {match_a[0], match_a[1], match_b[1], capture_a[1], capture_b[1]} = ev;
    cyc(1);
    {match_a[0], match_a[1], match_b[1], capture_a[1], capture_b[1]} = 5'h00;
    cyc(1);
    rd(4'h6, "counter clear", 16'h0000, 16'hffff, !zero);
    if (zero)
      chk("counter output", 16'h0000, channel_counter[1]);
  endtask : clr_case

  // One match or capture pulse on buffer k with the given enables
  task automatic buf_pulse(input int k, input logic cap, input logic [3:0] en);
    logic [4:0] ev;
    ev = 5'h01 << (3 + k / 2);
    buffer_enable = en;
    gcap_a = cap ? ev : 5'h00;
    gcap_b = gcap_a;
    {capture_b, capture_a, match_b, match_a} = {ev, ev, ev, ev} &
      {{5{cap & k[0]}}, {5{cap & !k[0]}}, {5{!cap & k[0]}}, {5{!cap & !k[0]}}};
    #1;
    if (!cap)
      chk("buffer load", 16'(en & (4'h1 << k)), 16'(buffer_load));
    cyc(1);
    {capture_b, capture_a, match_b, match_a} = 20'h0_0000;
  endtask : buf_pulse

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // Read data is compared with the oldest note one cycle after the strobe
  always @(posedge clk) rd_d <= bus_rd;
  always @(negedge clk)
  begin : monitor
    mctu_note_type n;
    if (rd_d)
    begin
      n = notes.pop_front();
      if (n.rel)
        chk(n.name, n.exp, (bus_rdata - prev_rd) & n.mask);
      else
        chk(n.name, n.exp, bus_rdata & n.mask);
      prev_rd = bus_rdata;
    end
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin : main
    int k;
    int e;
    mctu_word_type v;
    cyc(12);
    rst = 1'b0;
    cyc(1);
    // Reset values and unmapped reads
    for (k = 0; k < 5; k++)
      rd(k[3:0], "control reset", `MCTU_CTL_RST, 16'h00ff, 1'b0);
    for (k = 0; k < 4; k++)
      rd(4'(10 + k), "buffer reset", `MCTU_BUF_RST, 16'hffff, 1'b0);
    for (k = 14; k < 16; k++)
      rd(k[3:0], "unmapped", 16'h0000, 16'hffff, 1'b0);
    // Control write with bit 7 held at one
    for (k = 0; k < 5; k++)
    begin
      v = 16'($random(seed));
      wr(k[3:0], 2'b11, v);
      rd(k[3:0], "control rw", {8'h00, v[7:0] | 8'h80}, 16'h00ff, 1'b0);
    end
    // Buffer word and byte access
    for (k = 0; k < 4; k++)
    begin
      v = 16'($random(seed));
      wr(4'(10 + k), 2'b11, v);
      wr(4'(10 + k), 2'b01, ~v);
      rd(4'(10 + k), "buffer low", {v[15:8], ~v[7:0]}, 16'hffff, 1'b0);
      wr(4'(10 + k), 2'b10, 16'h0000);
      rd(4'(10 + k), "buffer high", {8'h00, ~v[7:0]}, 16'hffff, 1'b0);
    end
    // Internal prescaler, edge field random and ignored
    for (k = 0; k < 4; k++)
    begin
      v = 16'($random(seed));
      wr(4'h0, 2'b01, {8'h00, 3'b000, v[1:0], k[2:0]});
      rd(4'h5, "base", 16'h0000, 16'h0000, 1'b0);
      cyc(14);
      rd(4'h5, "prescaled", 16'h0010 >> k, 16'hffff, 1'b1);
    end
    // External inputs and edge choices on ch1
    for (k = 0; k < 4; k++)
      for (e = 0; e < 4; e++)
      begin
        wr(4'h1, 2'b01, {11'h000, e[1:0], 1'b1, k[1:0]});
        cyc(4);
        rd(4'h6, "base", 16'h0000, 16'h0000, 1'b0);
        ext[k] = 1'b1;
        cyc(6);
        rd(4'h6, "rise count", 16'(e != 1), 16'hffff, 1'b1);
        ext[k] = 1'b0;
        cyc(6);
        rd(4'h6, "fall count", 16'(e != 0), 16'hffff, 1'b1);
      end
    // Counter clear sources on ch1, ch0 as sync partner
    wr(4'h0, 2'b01, 16'h0024);
    sync = 5'h03;
    for (k = 0; k < 9; k++)
      clr_case(clr_ctl[k], clr_ev[k], clr_mode[k], clr_zero[k]);
    sync = 5'h01;
    clr_case(8'h64, 5'h10, 1'b0, 1'b0);
    // Phase mode on ch2 overrides the prescaler
    phase_mode = 1'b1;
    wr(4'h2, 2'b01, 16'h0000);
    for (k = 0; k < 4; k++)
    begin
      {phase_down, phase_up} = k[1:0];
      rd(4'h7, "base", 16'h0000, 16'h0000, 1'b0);
      cyc(14);
      {phase_down, phase_up} = 2'b00;
      rd(4'h7, "phase count", ph_exp[k], 16'hffff, 1'b1);
    end
    phase_mode = 1'b0;
    // Capture into buffers, enables, compare transfer requests
    for (k = 0; k < 4; k++)
    begin
      v = 16'($random(seed));
      gval[k] = v;
      buf_pulse(k, 1'b1, 4'h1 << k);
      rd(4'(10 + k), "capture buffer", v, 16'hffff, 1'b0);
      chk("buffer value", v, buffer_value[k]);
      gval[k] = ~v;
      buf_pulse(k, 1'b1, ~(4'h1 << k));
      rd(4'(10 + k), "disabled buffer", v, 16'hffff, 1'b0);
      buf_pulse(k, 1'b0, 4'h1 << k);
      buf_pulse(k, 1'b0, ~(4'h1 << k));
    end
    // Standby reloads reset values
    standby = 1'b1;
    cyc(1);
    standby = 1'b0;
    cyc(1);
    rd(4'ha, "standby buffer", `MCTU_BUF_RST, 16'hffff, 1'b0);
    rd(4'h3, "standby control", `MCTU_CTL_RST, 16'h00ff, 1'b0);
    for (k = 0; k < 20 && notes.size() > 0; k++)
      cyc(1);
    if (notes.size() != 0)
    begin
      n_errors++;
      $display("FAIL read results expected 0 seen %0d", notes.size());
    end
    results();
  end
endmodule : tb

`default_nettype wire
